//--- logic/tsc_map.svh
// register layout, command codes, reset values and timing of the port
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH
`define TSC_CMD_RD_TEMP 8'haa
`define TSC_CMD_RD_CNT 8'ha0
`define TSC_CMD_RD_SLOPE 8'ha9
`define TSC_CMD_WR_UPPER 8'h01
`define TSC_CMD_WR_LOWER 8'h02
`define TSC_CMD_RD_UPPER 8'ha1
`define TSC_CMD_RD_LOWER 8'ha2
`define TSC_CMD_START 8'hee
`define TSC_CMD_STOP 8'h22
`define TSC_CMD_WR_CFG 8'h0c
`define TSC_CMD_RD_CFG 8'hac
`define TSC_CFG_DONE 7
`define TSC_CFG_HIGH 6
`define TSC_CFG_LOW 5
`define TSC_CFG_NVB 4
`define TSC_CFG_ONE 3
`define TSC_CFG_ZERO 2
`define TSC_CFG_HOST 1
`define TSC_CFG_SINGLE 0
`define TSC_RST_TEMP 9'h188
`define TSC_RST_UPPER 9'h01e
`define TSC_RST_LOWER 9'h014
`define TSC_RST_HOST 1'h0
`define TSC_RST_SINGLE 1'h0
`define TSC_WORD_BITS 5'h09
`define TSC_CFG_BITS 5'h08
`define TSC_CMD_LAST 5'h07
`define TSC_WORD_LAST 5'h08
`define TSC_CNT_MAX 5'h1f
`define TSC_NV_WRITE_MS 10
`define TSC_CLK_KHZ 125000
`endif

//--- logic/tsc_pkg.sv
// types shared by the serial command port
package tsc_pkg;
   typedef enum logic [1:0] {LK_CMD, LK_READ, LK_WRITE, LK_IGNORE}
      tsc_link_state_t;
   typedef enum logic {CV_IDLE, CV_RUN} tsc_conv_state_t;
   typedef enum logic [2:0] {SEL_TEMP, SEL_CNT, SEL_SLOPE, SEL_UPPER,
      SEL_LOWER, SEL_CFG} tsc_read_sel_t;
   typedef logic signed [8:0] tsc_temp_t;
endpackage : tsc_pkg

//--- logic/tsc_serial_command_port.sv
// thermometer configuration, conversion control and three-wire port
`timescale 1ns/1ns
`include "tsc_map.svh"

module tsc_serial_command_port
   import tsc_pkg::*;
#(
   parameter int unsigned NV_WRITE_CYCLES = `TSC_NV_WRITE_MS * `TSC_CLK_KHZ
)
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic serial_clock_convert_pin,
   input wire logic port_enable,
   input wire logic dq_in,
   output logic dq_out,
   output logic dq_oe_n,
   input wire logic meas_valid,
   input wire tsc_temp_t meas_temp,
   input wire logic [8:0] meas_count,
   input wire logic [8:0] meas_slope,
   output logic conv_run,
   output logic thermo_high,
   output logic thermo_low,
   output logic hysteresis_output
);

   // ************************************************************
   // link side, rising serial clock
   // ************************************************************
   tsc_link_state_t lk_state_reg, lk_state_next;
   tsc_read_sel_t lk_sel_reg, lk_sel_next;
   logic [4:0] lk_cnt_reg, lk_cnt_next;
   logic [7:0] lk_cmd_reg, lk_cmd_next;
   logic [8:0] lk_shift_reg, lk_shift_next;
   logic [4:0] lk_wlast_reg, lk_wlast_next;
   logic [7:0] full_cmd;
   logic lk_fire;
   logic [7:0] lk_fire_cmd;
   logic evt_toggle_reg, evt_toggle_next;
   logic [7:0] evt_cmd_reg, evt_cmd_next;
   logic [8:0] evt_data_reg, evt_data_next;
   // snapshot words, frozen in the system domain while enable is high
   tsc_temp_t snap_temp_reg, snap_upper_reg, snap_lower_reg;
   logic [8:0] snap_cnt_reg, snap_slope_reg;
   logic [7:0] snap_cfg_reg;

   always_comb
   begin
      full_cmd = {dq_in, lk_cmd_reg[7:1]};
      lk_state_next = lk_state_reg;
      lk_sel_next = lk_sel_reg;
      lk_cnt_next = lk_cnt_reg;
      lk_cmd_next = lk_cmd_reg;
      lk_shift_next = lk_shift_reg;
      lk_wlast_next = lk_wlast_reg;
      lk_fire = 1'b0;
      lk_fire_cmd = lk_cmd_reg;
      unique case (lk_state_reg)
         LK_CMD:
         begin
            lk_cmd_next = full_cmd;
            lk_cnt_next = lk_cnt_reg + 5'h01;
            if (lk_cnt_reg == `TSC_CMD_LAST)
            begin
               lk_cnt_next = 5'h00;
               lk_state_next = LK_READ;
               unique case (full_cmd)
                  `TSC_CMD_RD_TEMP: lk_sel_next = SEL_TEMP;
                  `TSC_CMD_RD_CNT: lk_sel_next = SEL_CNT;
                  `TSC_CMD_RD_SLOPE: lk_sel_next = SEL_SLOPE;
                  `TSC_CMD_RD_UPPER: lk_sel_next = SEL_UPPER;
                  `TSC_CMD_RD_LOWER: lk_sel_next = SEL_LOWER;
                  `TSC_CMD_RD_CFG: lk_sel_next = SEL_CFG;
                  `TSC_CMD_WR_UPPER, `TSC_CMD_WR_LOWER:
                  begin
                     lk_state_next = LK_WRITE;
                     lk_wlast_next = `TSC_WORD_LAST;
                  end
                  `TSC_CMD_WR_CFG:
                  begin
                     lk_state_next = LK_WRITE;
                     lk_wlast_next = `TSC_CMD_LAST;
                  end
                  `TSC_CMD_START, `TSC_CMD_STOP:
                  begin
                     lk_state_next = LK_IGNORE;
                     lk_fire = 1'b1;
                     lk_fire_cmd = full_cmd;
                  end
                  default: lk_state_next = LK_IGNORE;
               endcase
            end
         end
         LK_READ:
         begin
            if (lk_cnt_reg != `TSC_CNT_MAX)
               lk_cnt_next = lk_cnt_reg + 5'h01;
         end
         LK_WRITE:
         begin
            lk_shift_next = {dq_in, lk_shift_reg[8:1]};
            lk_cnt_next = lk_cnt_reg + 5'h01;
            if (lk_cnt_reg == lk_wlast_reg)
            begin
               lk_fire = 1'b1;
               lk_state_next = LK_IGNORE;
            end
         end
         LK_IGNORE:
         begin
            lk_cnt_next = lk_cnt_reg;
         end
      endcase
      evt_toggle_next = evt_toggle_reg ^ lk_fire;
      evt_cmd_next = lk_fire ? lk_fire_cmd : evt_cmd_reg;
      evt_data_next = evt_data_reg;
      if (lk_fire && lk_state_reg == LK_WRITE)
      begin
         if (lk_cmd_reg == `TSC_CMD_WR_CFG)
            evt_data_next = {1'b0, lk_shift_next[8:1]};
         else
            evt_data_next = lk_shift_next;
      end
   end

   // enable low holds the frame logic in reset: abort
   always_ff @(posedge serial_clock_convert_pin or negedge port_enable)
   begin
      if (!port_enable)
      begin
         lk_state_reg <= LK_CMD;
         lk_sel_reg <= SEL_TEMP;
         lk_cnt_reg <= 5'h00;
         lk_cmd_reg <= 8'h00;
         lk_shift_reg <= 9'h000;
         lk_wlast_reg <= 5'h00;
      end
      else
      begin
         lk_state_reg <= lk_state_next;
         lk_sel_reg <= lk_sel_next;
         lk_cnt_reg <= lk_cnt_next;
         lk_cmd_reg <= lk_cmd_next;
         lk_shift_reg <= lk_shift_next;
         lk_wlast_reg <= lk_wlast_next;
      end
   end

   // finished requests outlive the frame so the system side can take them
   always_ff @(posedge serial_clock_convert_pin or negedge reset_n)
   begin
      if (!reset_n)
      begin
         evt_toggle_reg <= 1'b0;
         evt_cmd_reg <= 8'h00;
         evt_data_reg <= 9'h000;
      end
      else
      begin
         evt_toggle_reg <= evt_toggle_next;
         evt_cmd_reg <= evt_cmd_next;
         evt_data_reg <= evt_data_next;
      end
   end

   // ************************************************************
   // link side, falling serial clock: read data
   // ************************************************************
   logic [8:0] rd_word;
   logic [4:0] rd_len;
   logic bit_reg, bit_next;
   logic drive_reg, drive_next;

   always_comb
   begin
      rd_len = `TSC_WORD_BITS;
      unique case (lk_sel_reg)
         SEL_TEMP: rd_word = snap_temp_reg;
         SEL_CNT: rd_word = snap_cnt_reg;
         SEL_SLOPE: rd_word = snap_slope_reg;
         SEL_UPPER: rd_word = snap_upper_reg;
         SEL_LOWER: rd_word = snap_lower_reg;
         default:
         begin
            rd_word = {1'b0, snap_cfg_reg};
            rd_len = `TSC_CFG_BITS;
         end
      endcase
      drive_next = (lk_state_reg == LK_READ);
      bit_next = 1'b0;
      if (drive_next && lk_cnt_reg < rd_len)
         bit_next = rd_word[lk_cnt_reg[3:0]];
   end

   always_ff @(negedge serial_clock_convert_pin or negedge port_enable)
   begin
      if (!port_enable)
      begin
         bit_reg <= 1'b0;
         drive_reg <= 1'b0;
      end
      else
      begin
         bit_reg <= bit_next;
         drive_reg <= drive_next;
      end
   end

   assign dq_out = bit_reg;
   // released while the clock is high or enable is low
   assign dq_oe_n = ~(drive_reg & ~serial_clock_convert_pin &
      port_enable);

   // ************************************************************
   // system side: synchronisers, config, conversion control
   // ************************************************************
   logic pe_s1, pe_s2, ck_s1, ck_s2, tg_s1, tg_s2, tg_s3;
   tsc_conv_state_t cv_state_reg, cv_state_next;
   logic cont_reg, cont_next;
   logic high_flag_reg, high_flag_next;
   logic low_flag_reg, low_flag_next;
   logic host_mode_reg, host_mode_next;
   logic single_reg, single_next;
   tsc_temp_t upper_reg, upper_next, lower_reg, lower_next;
   tsc_temp_t temp_reg, temp_next;
   logic [8:0] cnt_reg, cnt_next, slope_reg, slope_next;
   logic [20:0] nv_cnt_reg, nv_cnt_next;
   logic th_out_reg, th_out_next, tl_out_reg, tl_out_next;
   logic hy_out_reg, hy_out_next;
   logic evt_pulse, conv_low, start_cmd, stop_cmd, cfg_wr, wr_up, wr_lo;
   logic done_evt, hi_hit, lo_hit;
   logic [7:0] cfg_value;

   always_comb
   begin
      evt_pulse = tg_s2 ^ tg_s3;
      start_cmd = evt_pulse && evt_cmd_reg == `TSC_CMD_START;
      stop_cmd = evt_pulse && evt_cmd_reg == `TSC_CMD_STOP;
      cfg_wr = evt_pulse && evt_cmd_reg == `TSC_CMD_WR_CFG;
      wr_up = evt_pulse && evt_cmd_reg == `TSC_CMD_WR_UPPER;
      wr_lo = evt_pulse && evt_cmd_reg == `TSC_CMD_WR_LOWER;
      conv_low = ~host_mode_reg & ~pe_s2 & ~ck_s2;
      done_evt = (cv_state_reg == CV_RUN) && meas_valid;
      hi_hit = meas_temp >= upper_reg;
      lo_hit = meas_temp <= lower_reg;
      cfg_value = {cv_state_reg == CV_IDLE, high_flag_reg, low_flag_reg,
         nv_cnt_reg != 21'h000000, 1'b1, 1'b0, host_mode_reg,
         single_reg};
      cv_state_next = cv_state_reg;
      cont_next = cont_reg;
      if (start_cmd)
         cont_next = ~single_reg;
      if (stop_cmd)
         cont_next = 1'b0;
      unique case (cv_state_reg)
         CV_IDLE:
            if (start_cmd || conv_low)
               cv_state_next = CV_RUN;
         CV_RUN:
            if (done_evt && !(cont_next || conv_low))
               cv_state_next = CV_IDLE;
      endcase
      temp_next = done_evt ? meas_temp : temp_reg;
      cnt_next = done_evt ? meas_count : cnt_reg;
      slope_next = done_evt ? meas_slope : slope_reg;
      th_out_next = done_evt ? hi_hit : th_out_reg;
      tl_out_next = done_evt ? lo_hit : tl_out_reg;
      hy_out_next = hy_out_reg;
      if (done_evt && hi_hit)
         hy_out_next = 1'b1;
      else if (done_evt && lo_hit)
         hy_out_next = 1'b0;
      // a set in the same cycle as a clearing write wins
      high_flag_next = (cfg_wr ? evt_data_reg[`TSC_CFG_HIGH] : high_flag_reg)
         | (done_evt & hi_hit);
      low_flag_next = (cfg_wr ? evt_data_reg[`TSC_CFG_LOW] : low_flag_reg)
         | (done_evt & lo_hit);
      host_mode_next = cfg_wr ? evt_data_reg[`TSC_CFG_HOST] : host_mode_reg;
      single_next = cfg_wr ? evt_data_reg[`TSC_CFG_SINGLE] : single_reg;
      upper_next = wr_up ? evt_data_reg : upper_reg;
      lower_next = wr_lo ? evt_data_reg : lower_reg;
      nv_cnt_next = nv_cnt_reg;
      if (cfg_wr || wr_up || wr_lo)
         nv_cnt_next = 21'(NV_WRITE_CYCLES);
      else if (nv_cnt_reg != 21'h000000)
         nv_cnt_next = nv_cnt_reg - 21'h000001;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pe_s1 <= 1'b0;
         pe_s2 <= 1'b0;
         ck_s1 <= 1'b1;
         ck_s2 <= 1'b1;
         tg_s1 <= 1'b0;
         tg_s2 <= 1'b0;
         tg_s3 <= 1'b0;
         cv_state_reg <= CV_IDLE;
         cont_reg <= 1'b0;
         high_flag_reg <= 1'b0;
         low_flag_reg <= 1'b0;
         host_mode_reg <= `TSC_RST_HOST;
         single_reg <= `TSC_RST_SINGLE;
         upper_reg <= `TSC_RST_UPPER;
         lower_reg <= `TSC_RST_LOWER;
         temp_reg <= `TSC_RST_TEMP;
         cnt_reg <= 9'h000;
         slope_reg <= 9'h000;
         nv_cnt_reg <= 21'h000000;
         th_out_reg <= 1'b0;
         tl_out_reg <= 1'b0;
         hy_out_reg <= 1'b0;
      end
      else
      begin
         pe_s1 <= port_enable;
         pe_s2 <= pe_s1;
         ck_s1 <= serial_clock_convert_pin;
         ck_s2 <= ck_s1;
         tg_s1 <= evt_toggle_reg;
         tg_s2 <= tg_s1;
         tg_s3 <= tg_s2;
         cv_state_reg <= cv_state_next;
         cont_reg <= cont_next;
         high_flag_reg <= high_flag_next;
         low_flag_reg <= low_flag_next;
         host_mode_reg <= host_mode_next;
         single_reg <= single_next;
         upper_reg <= upper_next;
         lower_reg <= lower_next;
         temp_reg <= temp_next;
         cnt_reg <= cnt_next;
         slope_reg <= slope_next;
         nv_cnt_reg <= nv_cnt_next;
         th_out_reg <= th_out_next;
         tl_out_reg <= tl_out_next;
         hy_out_reg <= hy_out_next;
      end
   end

   // snapshot follows live state between frames, holds during a frame
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         snap_temp_reg <= `TSC_RST_TEMP;
         snap_cnt_reg <= 9'h000;
         snap_slope_reg <= 9'h000;
         snap_upper_reg <= `TSC_RST_UPPER;
         snap_lower_reg <= `TSC_RST_LOWER;
         snap_cfg_reg <= 8'h88;
      end
      else if (!pe_s2)
      begin
         snap_temp_reg <= temp_reg;
         snap_cnt_reg <= cnt_reg;
         snap_slope_reg <= slope_reg;
         snap_upper_reg <= upper_reg;
         snap_lower_reg <= lower_reg;
         snap_cfg_reg <= cfg_value;
      end
   end

   assign conv_run = (cv_state_reg == CV_RUN);
   assign thermo_high = th_out_reg;
   assign thermo_low = tl_out_reg;
   assign hysteresis_output = hy_out_reg;

endmodule : tsc_serial_command_port

//--- testbench/tsc_serial_command_port_assertions.sv
// checker for the thermometer serial command port
`timescale 1ns/1ns
`include "tsc_map.svh"
module tsc_serial_command_port_assertions
   import tsc_pkg::*;
#(
   parameter int unsigned NV_WRITE_CYCLES = `TSC_NV_WRITE_MS * `TSC_CLK_KHZ
)
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic serial_clock_convert_pin,
   input wire logic port_enable,
   input wire logic dq_in,
   input wire logic dq_out,
   input wire logic dq_oe_n,
   input wire logic meas_valid,
   input wire tsc_temp_t meas_temp,
   input wire logic [8:0] meas_count,
   input wire logic [8:0] meas_slope,
   input wire logic conv_run,
   input wire logic thermo_high,
   input wire logic thermo_low,
   input wire logic hysteresis_output
);
   // ****
   // frame tracking in the serial clock domain
   // ****
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   logic [7:0] cmd_reg;
   logic [7:0] cmd_next;
   logic rd_cmd;
   logic [4:0] tail;
   always_comb
   begin
      cnt_next = cnt_reg;
      cmd_next = cmd_reg;
      if (cnt_reg < 5'h08)
         cmd_next = {dq_in, cmd_reg[7:1]};
      if (cnt_reg != `TSC_CNT_MAX)
         cnt_next = cnt_reg + 5'h01;
   end
   always_ff @(posedge serial_clock_convert_pin or negedge port_enable)
   begin
      if (!port_enable)
      begin
         cnt_reg <= 5'h00;
         cmd_reg <= 8'h00;
      end
      else
      begin
         cnt_reg <= cnt_next;
         cmd_reg <= cmd_next;
      end
   end
   assign rd_cmd = cmd_reg inside {`TSC_CMD_RD_TEMP, `TSC_CMD_RD_CNT,
      `TSC_CMD_RD_SLOPE, `TSC_CMD_RD_UPPER, `TSC_CMD_RD_LOWER,
      `TSC_CMD_RD_CFG};
   assign tail = (cmd_reg == `TSC_CMD_RD_CFG) ? 5'h10 : 5'h11;
   a_oe_clk_low:
   assert property (@(posedge mclk) disable iff (!reset_n)
      !dq_oe_n |-> !serial_clock_convert_pin) else $error("drive in high");
   a_oe_pe_off:
   assert property (@(posedge mclk) disable iff (!reset_n)
      !port_enable |-> dq_oe_n) else $error("drive without enable");
   a_thermo_hold:
   assert property (@(posedge mclk) disable iff (!reset_n)
      $changed({thermo_high, thermo_low, hysteresis_output})
      |-> $past(meas_valid) && $past(conv_run)) else $error("output moved");
   a_hyst_rise:
   assert property (@(posedge mclk) disable iff (!reset_n)
      $rose(hysteresis_output) |-> thermo_high) else $error("bad rise");
   a_hyst_fall:
   assert property (@(posedge mclk) disable iff (!reset_n)
      $fell(hysteresis_output) |-> thermo_low) else $error("bad fall");
   a_cmd_quiet:
   assert property (@(posedge serial_clock_convert_pin)
      disable iff (!port_enable) cnt_reg < 5'h08 |-> dq_oe_n)
      else $error("drive during command");
   a_read_drive:
   assert property (@(posedge serial_clock_convert_pin)
      disable iff (!port_enable) cnt_reg >= 5'h08 && cnt_reg < tail
      && rd_cmd |-> !dq_oe_n) else $error("read bit not driven");
   a_zero_tail:
   assert property (@(posedge serial_clock_convert_pin)
      disable iff (!port_enable) cnt_reg >= tail && rd_cmd
      |-> !dq_oe_n && !dq_out) else $error("tail not zero");
   a_other_quiet:
   assert property (@(posedge serial_clock_convert_pin)
      disable iff (!port_enable) cnt_reg >= 5'h08 && !rd_cmd
      |-> dq_oe_n) else $error("drive after non-read command");
   c_conv: cover property (@(posedge mclk) meas_valid && conv_run);
   c_hyst: cover property (@(posedge mclk) $rose(hysteresis_output));
   c_read: cover property (@(posedge serial_clock_convert_pin)
      cnt_reg == 5'h10 && rd_cmd);
endmodule : tsc_serial_command_port_assertions

bind tsc_serial_command_port tsc_serial_command_port_assertions
   #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk (.mclk, .reset_n,
   .serial_clock_convert_pin, .port_enable, .dq_in, .dq_out, .dq_oe_n,
   .meas_valid, .meas_temp, .meas_count, .meas_slope, .conv_run,
   .thermo_high, .thermo_low, .hysteresis_output);

//--- testbench/tsc_host_model.sv
// host controller model driving the three-wire port
`timescale 1ns/1ns
module tsc_host_model
(
   output logic serial_clock_convert_pin,
   output logic port_enable,
   output wire logic dq_in,
   input wire logic dq_out,
   input wire logic dq_oe_n
);
   logic host_oe = 1'b0;
   logic host_d = 1'b1;
   // pulled-up data line
   assign dq_in = host_oe ? host_d : (!dq_oe_n ? dq_out : 1'b1);
   initial
   begin
      serial_clock_convert_pin = 1'b1;
      port_enable = 1'b0;
   end
   // one 30 ns cycle, read bit taken just before the rise
   task cycle(input logic drv, input logic b, output logic got);
      serial_clock_convert_pin = 1'b0;
      host_oe = drv;
      host_d = b;
      #14;
      got = dq_in;
      #1;
      serial_clock_convert_pin = 1'b1;
      #15;
   endtask : cycle
   task frame(input logic [7:0] c, input int wn, input logic [15:0] wd,
      input int rn, output logic [15:0] rd);
      logic b;
      rd = 16'h0000;
      port_enable = 1'b1;
      #120;
      for (int i = 0; i < 8; i++)
         cycle(1'b1, c[i], b);
      for (int i = 0; i < wn; i++)
         cycle(1'b1, wd[i], b);
      for (int i = 0; i < rn; i++)
      begin
         cycle(1'b0, 1'b0, b);
         rd[i] = b;
      end
      host_oe = 1'b0;
      #45;
      port_enable = 1'b0;
      #200;
   endtask : frame
   task conv_low(input int t);
      serial_clock_convert_pin = 1'b0;
      #(t);
      serial_clock_convert_pin = 1'b1;
   endtask : conv_low
endmodule : tsc_host_model

//--- testbench/tsc_serial_command_port_bench.sv
// self-checking bench for the thermometer serial command port
`timescale 1ns/1ns
`include "tsc_map.svh"
module tsc_serial_command_port_bench
   import tsc_pkg::*;
;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic meas_valid = 1'b0;
   tsc_temp_t meas_temp = 9'h000;
   logic [8:0] meas_count = 9'h0a5;
   logic [8:0] meas_slope = 9'h15a;
   wire logic serial_clock_convert_pin;
   wire logic port_enable;
   wire logic dq_in;
   wire logic dq_out;
   wire logic dq_oe_n;
   wire logic conv_run;
   wire logic thermo_high;
   wire logic thermo_low;
   wire logic hysteresis_output;
   int n_mismatch = 0;
   int comparisons = 0;
   int n_conv = 0;
   int conv_cnt = 0;
   int cyc = 0;
   int n0;
   tsc_serial_command_port #(.NV_WRITE_CYCLES(80)) dut (.mclk, .reset_n,
      .serial_clock_convert_pin, .port_enable, .dq_in, .dq_out, .dq_oe_n,
      .meas_valid, .meas_temp, .meas_count, .meas_slope, .conv_run,
      .thermo_high, .thermo_low, .hysteresis_output);
   tsc_host_model host (.serial_clock_convert_pin, .port_enable, .dq_in,
      .dq_out, .dq_oe_n);
   always #4 mclk = ~mclk;
   // sensor: a conversion takes 100 cycles
   always @(negedge mclk)
   begin
      meas_valid <= 1'b0;
      conv_cnt <= conv_cnt + 1;
      if (conv_run !== 1'b1)
         conv_cnt <= 0;
      else if (conv_cnt == 99)
      begin
         conv_cnt <= 0;
         meas_valid <= 1'b1;
         n_conv <= n_conv + 1;
      end
   end
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         conclude();
      end
   end
   task conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude
   task cmp(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got,
            exp);
      end
   endtask : cmp
   task cmp_bit(input logic got, input logic exp);
      cmp({15'h0000, got}, {15'h0000, exp});
   endtask : cmp_bit
   task rd(input logic [7:0] c, input int n, input logic [15:0] e);
      logic [15:0] v;
      host.frame(c, 0, 16'h0000, n, v);
      cmp(v, e);
   endtask : rd
   task wr(input logic [7:0] c, input int n, input logic [15:0] d);
      logic [15:0] v;
      host.frame(c, n, d, 0, v);
   endtask : wr
   task wt(input int n);
      repeat (n) @(negedge mclk);
   endtask : wt
   task idle();
      int i;
      i = 0;
      while (conv_run !== 1'b0 && i < 400)
      begin
         @(negedge mclk);
         i++;
      end
      cmp_bit(conv_run, 1'b0);
   endtask : idle
   initial
   begin
      wt(16);
      reset_n = 1'b1;
      wt(4);
      rd(`TSC_CMD_RD_CFG, 8, 16'h0088);
      rd(`TSC_CMD_RD_UPPER, 9, 16'h001e);
      rd(`TSC_CMD_RD_LOWER, 9, 16'h0014);
      rd(`TSC_CMD_RD_TEMP, 12, 16'h0188);
      $display("reset test ends");
      wr(`TSC_CMD_WR_UPPER, 9, 16'h0050);
      rd(`TSC_CMD_RD_CFG, 8, 16'h0098);
      wt(100);
      rd(`TSC_CMD_RD_CFG, 8, 16'h0088);
      wr(`TSC_CMD_WR_LOWER, 9, 16'h01f0);
      wt(100);
      rd(`TSC_CMD_RD_UPPER, 9, 16'h0050);
      rd(`TSC_CMD_RD_LOWER, 9, 16'h01f0);
      $display("limit test ends");
      wr(`TSC_CMD_WR_CFG, 8, 16'h0001);
      wt(100);
      rd(`TSC_CMD_RD_CFG, 8, 16'h0089);
      @(negedge mclk) meas_temp = 9'h060;
      n0 = n_conv;
      wr(`TSC_CMD_START, 0, 16'h0000);
      cmp_bit(conv_run, 1'b1);
      idle();
      cmp(16'(n_conv - n0), 16'h0001);
      cmp({13'h0, thermo_high, thermo_low, hysteresis_output}, 16'h5);
      rd(`TSC_CMD_RD_CFG, 8, 16'h00c9);
      rd(`TSC_CMD_RD_TEMP, 9, 16'h0060);
      rd(`TSC_CMD_RD_CNT, 9, 16'h00a5);
      rd(`TSC_CMD_RD_SLOPE, 9, 16'h015a);
      @(negedge mclk) meas_temp = 9'h1e0;
      wt(50);
      cmp_bit(thermo_high, 1'b1);
      $display("one-shot test ends");
      wr(`TSC_CMD_WR_CFG, 8, 16'h0001);
      wt(100);
      rd(`TSC_CMD_RD_CFG, 8, 16'h0089);
      wr(`TSC_CMD_START, 0, 16'h0000);
      idle();
      cmp({13'h0, thermo_high, thermo_low, hysteresis_output}, 16'h2);
      rd(`TSC_CMD_RD_CFG, 8, 16'h00a9);
      $display("low flag test ends");
      n0 = n_conv;
      host.conv_low(64);
      wt(150);
      idle();
      cmp(16'(n_conv - n0), 16'h0001);
      n0 = n_conv;
      host.conv_low(3000);
      idle();
      cmp_bit(n_conv - n0 >= 3, 1'b1);
      $display("stand-alone test ends");
      wr(`TSC_CMD_WR_CFG, 8, 16'h0000);
      wt(100);
      n0 = n_conv;
      wr(`TSC_CMD_START, 0, 16'h0000);
      wt(250);
      cmp_bit(n_conv - n0 >= 2 && conv_run, 1'b1);
      rd(`TSC_CMD_RD_CFG, 8, 16'h0028);
      wr(`TSC_CMD_STOP, 0, 16'h0000);
      idle();
      wt(300);
      cmp_bit(conv_run, 1'b0);
      $display("continuous test ends");
      wr(`TSC_CMD_WR_CFG, 8, 16'h0002);
      wt(100);
      n0 = n_conv;
      host.conv_low(200);
      wt(150);
      cmp(16'(n_conv - n0), 16'h0000);
      rd(`TSC_CMD_RD_CFG, 8, 16'h008a);
      rd(8'h55, 16, 16'hffff);
      wr(`TSC_CMD_WR_UPPER, 4, 16'h000f);
      wt(100);
      rd(`TSC_CMD_RD_UPPER, 9, 16'h0050);
      $display("host mode test ends");
      conclude();
   end
endmodule : tsc_serial_command_port_bench
